// ---- src/otac_device.sv ----
// operand type decode and alignment check, execution_unit side
// assumes one request in flight; the issuer waits for each answer
// the issuer already filters misaligned commands; the check here is a second guard
// a refused request still ends the thread when it carries the end flag
`timescale 1ns/1ps
`default_nettype none
module otac_device
  import otac_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  otac_if.device link,
  output logic [OTAC_SLOT_W-1:0] thread_slot_id_o,
  output logic thread_active_o
);
  // ***************************************************
  // state
  // ***************************************************
  // q holds the slot id, the running flag and the answer fields
  // one packed register keeps every output on a flop
  typedef struct packed {
    logic [OTAC_SLOT_W-1:0] thread_slot_id; // slot running the thread
    logic active; // thread alive
    logic rsp_valid;
    otac_err_t rsp_err;
    logic [OTAC_RES_W-1:0] rsp_data;
    logic [OTAC_MASK_W-1:0] rsp_mask;
    logic rsp_done;
  } otac_dev_state_t;

  otac_dev_state_t q; // registered state
  otac_dev_state_t next_q; // next state

  // ***************************************************
  // conversion helpers
  // ***************************************************
  // packed nibble vector widened to eight signed words
  function automatic logic [OTAC_RES_W-1:0] nib_expand(input logic [OTAC_DATA_W-1:0] v);
    logic [OTAC_RES_W-1:0] r;
    r = '0;
    // sign extend each nibble
    // element i sits at bits 4i+3..4i, lane i at word i
    for (int i = 0; i < OTAC_NIB_CNT; i++) begin
      r[OTAC_NIB_OUT_W*i +: OTAC_NIB_OUT_W] =
        {{(OTAC_NIB_OUT_W-OTAC_NIB_W){v[OTAC_NIB_W*i+OTAC_NIB_W-1]}}, v[OTAC_NIB_W*i +: OTAC_NIB_W]};
    end
    return r;
  endfunction

  // packed minifloat vector widened to four singles
  function automatic logic [OTAC_RES_W-1:0] mf_expand(input logic [OTAC_DATA_W-1:0] v);
    logic [OTAC_RES_W-1:0] r;
    logic [OTAC_MF_W-1:0] b;
    r = '0;
    b = '0;
    for (int i = 0; i < OTAC_MF_CNT; i++) begin
      b = v[OTAC_MF_W*i +: OTAC_MF_W];
      if (b[OTAC_MF_EXP_HI:0] == 7'h00) begin
        // zero keeps its sign only; the +124 exponent rebias would turn it into 0.125
        r[OTAC_F32_W*i +: OTAC_F32_W] = {b[OTAC_MF_SIGN], 31'h0};
      end else begin
        // excess-3 to excess-127: copy top bit, fill inverted, keep low two
        r[OTAC_F32_W*i +: OTAC_F32_W] = {b[OTAC_MF_SIGN], b[OTAC_MF_EXP_HI], {5{~b[OTAC_MF_EXP_HI]}},
          b[OTAC_MF_EXP_HI-1 -: 2], b[OTAC_MF_MANT_W-1:0], {OTAC_F32_PAD_W{1'b0}}};
      end
    end
    return r;
  endfunction

  // scalar widened to 32 bits in lane 0
  function automatic logic [OTAC_RES_W-1:0] scalar_expand(input otac_type_t t,
                                                          input logic [OTAC_ADDR_W-1:0] a,
                                                          input logic [OTAC_DATA_W-1:0] v);
    logic [OTAC_DATA_W-1:0] byte_sel;
    logic [OTAC_DATA_W-1:0] word_sel;
    logic [OTAC_DATA_W-1:0] w;
    // lane select by address
    // low address bits pick the lane, byte 0 on the right
    byte_sel = v >> {a[1:0], 3'h0};
    word_sel = v >> {a[1], 4'h0};
    w = v;
    case (t)
      otac_ty_u8: w = {24'h000000, byte_sel[7:0]};
      otac_ty_s8: w = {{24{byte_sel[7]}}, byte_sel[7:0]};
      otac_ty_u16: w = {16'h0000, word_sel[15:0]};
      otac_ty_s16: w = {{16{word_sel[15]}}, word_sel[15:0]};
      default: w = v; // 32-bit types pass unchanged
    endcase
    return {96'h0, w};
  endfunction

  // ***************************************************
  // next-state logic
  // ***************************************************
  // decode, check and answer one request per cycle
  // back to back requests are fine; nothing here waits
  always_comb begin
    next_q = q;
    next_q.rsp_valid = 1'b0;
    next_q.rsp_done = 1'b0;
    if (link.disp_valid) begin
      next_q.thread_slot_id = link.disp_slot;
      next_q.active = 1'b1;
    end
    if (link.req_valid) begin
      next_q.rsp_valid = 1'b1;
      next_q.rsp_err = otac_err_none;
      next_q.rsp_data = '0;
      next_q.rsp_mask = '0;
      // refusal order: dead, halfbyte, alignment, type
      if (!q.active) begin
        // a finished or never-dispatched thread gets nothing
        next_q.rsp_err = otac_err_dead;
      end else if (link.req_unit == otac_un_halfbyte) begin
        next_q.rsp_err = otac_err_halfbyte;
      end else if (!otac_aligned(link.req_unit, link.req_addr)) begin
        next_q.rsp_err = otac_err_align;
      end else begin
        case (link.req_type)
          otac_ty_nib_vec: begin
            // immediate dword only
            if (!link.req_imm || link.req_unit != otac_un_dword) begin
              next_q.rsp_err = otac_err_type;
            end else begin
              next_q.rsp_data = nib_expand(link.req_data);
              next_q.rsp_mask = OTAC_MASK_NIB;
            end
          end
          otac_ty_mf_vec: begin
            if (!link.req_imm || link.req_unit != otac_un_dword) begin
              next_q.rsp_err = otac_err_type;
            end else begin
              next_q.rsp_data = mf_expand(link.req_data);
              next_q.rsp_mask = OTAC_MASK_MF;
            end
          end
          // scalars and groups; units above a dword carry no numeric value
          default: begin
            if (link.req_unit > otac_un_dword) begin
              next_q.rsp_data = {96'h0, link.req_data};
              next_q.rsp_mask = OTAC_MASK_ONE;
            end else begin
              next_q.rsp_data = scalar_expand(link.req_type, link.req_addr, link.req_data);
              next_q.rsp_mask = OTAC_MASK_ONE;
            end
          end
        endcase
      end
      if (q.active && link.req_eot) begin
        // last instruction ends thread
        // a dispatch landing in the same cycle wins over the end
        next_q.active = link.disp_valid;
        next_q.rsp_done = 1'b1;
      end
    end
  end

  // ***************************************************
  // registers
  // ***************************************************
  // whole state in one register
  // reset: no thread running, no answer pending
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= '{thread_slot_id: OTAC_SLOT_RST, active: 1'b0, rsp_valid: 1'b0, rsp_err: otac_err_none,
             rsp_data: '0, rsp_mask: '0, rsp_done: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  // ***************************************************
  // outputs, straight from flops
  // ***************************************************
  // answer fields hold until the next answer
  assign link.rsp_valid = q.rsp_valid;
  assign link.rsp_err = q.rsp_err;
  assign link.rsp_data = q.rsp_data;
  assign link.rsp_mask = q.rsp_mask;
  assign link.rsp_done = q.rsp_done;
  assign thread_slot_id_o = q.thread_slot_id;
  assign thread_active_o = q.active;
endmodule
`default_nettype wire

// ---- src/otac_if.sv ----
// operand type / alignment check: link between thread issuer and decoder
// assumes both ends share one clock outside this interface
`timescale 1ns/1ps
`default_nettype none
interface otac_if;
  import otac_pkg::*;
  logic disp_valid; // thread dispatch pulse
  logic [OTAC_SLOT_W-1:0] disp_slot; // slot of the dispatched thread
  logic req_valid; // access request pulse
  otac_type_t req_type;
  otac_unit_t req_unit;
  logic [OTAC_ADDR_W-1:0] req_addr;
  logic [OTAC_DATA_W-1:0] req_data;
  logic req_imm; // operand is an immediate
  logic req_eot; // end_of_thread_flag on a send
  logic rsp_valid; // answer pulse
  otac_err_t rsp_err;
  logic [OTAC_RES_W-1:0] rsp_data;
  logic [OTAC_MASK_W-1:0] rsp_mask;
  logic rsp_done; // thread ended with this answer
  modport device (
    input disp_valid, disp_slot, req_valid, req_type, req_unit, req_addr, req_data, req_imm, req_eot,
    output rsp_valid, rsp_err, rsp_data, rsp_mask, rsp_done
  );
  modport issuer (
    output disp_valid, disp_slot, req_valid, req_type, req_unit, req_addr, req_data, req_imm, req_eot,
    input rsp_valid, rsp_err, rsp_data, rsp_mask, rsp_done
  );
endinterface
`default_nettype wire

// ---- src/otac_issuer.sv ----
// thread side: dispatches a thread and issues operand accesses one at a time
// assumes the decoder answers every request exactly one cycle later
`timescale 1ns/1ps
`default_nettype none
module otac_issuer
  import otac_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  otac_if.issuer link,
  input wire logic dispatch_i, // start a thread when idle
  input wire logic [OTAC_SLOT_W-1:0] slot_i,
  input wire logic cmd_valid_i, // access command
  input wire otac_type_t cmd_type_i,
  input wire otac_unit_t cmd_unit_i,
  input wire logic [OTAC_ADDR_W-1:0] cmd_addr_i,
  input wire logic [OTAC_DATA_W-1:0] cmd_data_i,
  input wire logic cmd_imm_i,
  input wire logic cmd_eot_i,
  output logic cmd_ready_o, // command taken this cycle when high with valid
  output logic result_valid_o,
  output otac_err_t result_err_o,
  output logic [OTAC_RES_W-1:0] result_data_o,
  output logic [OTAC_MASK_W-1:0] result_mask_o,
  output logic thread_done_o
);
  // ***************************************************
  // state
  // ***************************************************
  typedef enum {otac_st_idle, otac_st_run, otac_st_wait} otac_iss_st_t;
  typedef struct packed {
    otac_iss_st_t st;
    logic disp_valid;
    logic [OTAC_SLOT_W-1:0] disp_slot;
    logic req_valid;
    otac_type_t req_type;
    otac_unit_t req_unit;
    logic [OTAC_ADDR_W-1:0] req_addr;
    logic [OTAC_DATA_W-1:0] req_data;
    logic req_imm;
    logic req_eot;
    logic res_valid;
    otac_err_t res_err;
    logic [OTAC_RES_W-1:0] res_data;
    logic [OTAC_MASK_W-1:0] res_mask;
    logic done;
    logic ready; // cmd_ready_o flop
  } otac_iss_state_t;

  otac_iss_state_t q; // registered state
  otac_iss_state_t next_q; // next state

  // ***************************************************
  // next-state logic
  // ***************************************************
  always_comb begin
    next_q = q;
    next_q.disp_valid = 1'b0;
    next_q.req_valid = 1'b0;
    next_q.res_valid = 1'b0;
    next_q.done = 1'b0;
    case (q.st)
      otac_st_idle: begin
        // new thread only when none is running
        if (dispatch_i) begin
          next_q.disp_valid = 1'b1;
          next_q.disp_slot = slot_i;
          next_q.st = otac_st_run;
        end
      end
      otac_st_run: begin
        if (cmd_valid_i) begin
          if (cmd_unit_i != otac_un_halfbyte && !otac_aligned(cmd_unit_i, cmd_addr_i)) begin
            // misaligned never leaves this end; answered locally
            next_q.res_valid = 1'b1;
            next_q.res_err = otac_err_align;
            next_q.res_data = '0;
            next_q.res_mask = '0;
          end else begin
            next_q.req_valid = 1'b1;
            next_q.req_type = cmd_type_i;
            next_q.req_unit = cmd_unit_i;
            next_q.req_addr = cmd_addr_i;
            next_q.req_data = cmd_data_i;
            next_q.req_imm = cmd_imm_i;
            next_q.req_eot = cmd_eot_i;
            next_q.st = otac_st_wait;
          end
        end
      end
      otac_st_wait: begin
        if (link.rsp_valid) begin
          next_q.res_valid = 1'b1;
          next_q.res_err = link.rsp_err;
          next_q.res_data = link.rsp_data;
          next_q.res_mask = link.rsp_mask;
          next_q.done = link.rsp_done;
          next_q.st = link.rsp_done ? otac_st_idle : otac_st_run;
        end
      end
      default: next_q.st = otac_st_idle;
    endcase
    // ready flop follows the state just entered
    next_q.ready = (next_q.st == otac_st_run);
  end

  // ***************************************************
  // registers
  // ***************************************************
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= '{st: otac_st_idle, disp_valid: 1'b0, disp_slot: OTAC_SLOT_RST, req_valid: 1'b0,
             req_type: otac_ty_u8, req_unit: otac_un_byte, req_addr: '0, req_data: '0, req_imm: 1'b0,
             req_eot: 1'b0, res_valid: 1'b0, res_err: otac_err_none, res_data: '0, res_mask: '0,
             done: 1'b0, ready: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  // ***************************************************
  // outputs
  // ***************************************************
  assign link.disp_valid = q.disp_valid;
  assign link.disp_slot = q.disp_slot;
  assign link.req_valid = q.req_valid;
  assign link.req_type = q.req_type;
  assign link.req_unit = q.req_unit;
  assign link.req_addr = q.req_addr;
  assign link.req_data = q.req_data;
  assign link.req_imm = q.req_imm;
  assign link.req_eot = q.req_eot;
  // ready comes from its own flop, not a state decode
  assign cmd_ready_o = q.ready;
  assign result_valid_o = q.res_valid;
  assign result_err_o = q.res_err;
  assign result_data_o = q.res_data;
  assign result_mask_o = q.res_mask;
  assign thread_done_o = q.done;
endmodule
`default_nettype wire

// ---- src/otac_pkg.sv ----
// operand type / alignment check: shared types, constants and helpers
// assumes both ends of the link import this package
package otac_pkg;
  // ***************************************************
  // widths and counts
  // ***************************************************
  localparam int OTAC_ADDR_W = 16; // byte address width
  localparam int OTAC_DATA_W = 32; // raw operand word
  localparam int OTAC_RES_W = 128; // widened result
  localparam int OTAC_SLOT_W = 2; // thread slot id
  localparam int OTAC_MASK_W = 8; // channel enables
  localparam int OTAC_NIB_W = 4; // packed nibble element
  localparam int OTAC_NIB_CNT = 8;
  localparam int OTAC_NIB_OUT_W = 16; // nibble widened to a word
  localparam int OTAC_MF_W = 8; // packed minifloat element
  localparam int OTAC_MF_CNT = 4;
  localparam int OTAC_MF_SIGN = 7; // sign bit position
  localparam int OTAC_MF_EXP_HI = 6; // exponent bits 6..4
  localparam int OTAC_MF_MANT_W = 4; // mantissa bits 3..0
  localparam int OTAC_F32_PAD_W = 19; // low mantissa fill of a single
  localparam int OTAC_F32_W = 32;
  localparam logic [OTAC_MASK_W-1:0] OTAC_MASK_NIB = 8'hff; // eight lanes
  localparam logic [OTAC_MASK_W-1:0] OTAC_MASK_MF = 8'h0f; // four lanes
  localparam logic [OTAC_MASK_W-1:0] OTAC_MASK_ONE = 8'h01; // lane 0 only
  localparam logic [OTAC_SLOT_W-1:0] OTAC_SLOT_RST = 2'h0;

  // ***************************************************
  // enumerations
  // ***************************************************
  // operand numeric types; nothing wider than 32 bits exists
  typedef enum logic [3:0] {
    otac_ty_u8, otac_ty_s8, otac_ty_u16, otac_ty_s16,
    otac_ty_u32, otac_ty_s32, otac_ty_f32, otac_ty_nib_vec, otac_ty_mf_vec
  } otac_type_t;
  // access units, log2 of size in halfbytes
  typedef enum logic [2:0] {
    otac_un_halfbyte, otac_un_byte, otac_un_word, otac_un_dword,
    otac_un_sixty_four_bit_unit, otac_un_dqword, otac_un_two_fifty_six_bit_unit
  } otac_unit_t;
  // answer codes
  typedef enum logic [2:0] {
    otac_err_none, otac_err_align, otac_err_halfbyte, otac_err_type, otac_err_dead
  } otac_err_t;

  // ***************************************************
  // helpers
  // ***************************************************
  // natural boundary test, used by both ends
  function automatic logic otac_aligned(input otac_unit_t u, input logic [OTAC_ADDR_W-1:0] a);
    logic ok;
    ok = 1'b1;
    case (u)
      otac_un_word: ok = (a[0] == 1'b0);
      otac_un_dword: ok = (a[1:0] == 2'h0);
      otac_un_sixty_four_bit_unit: ok = (a[2:0] == 3'h0);
      otac_un_dqword: ok = (a[3:0] == 4'h0);
      otac_un_two_fifty_six_bit_unit: ok = (a[4:0] == 5'h00);
      default: ok = 1'b1;
    endcase
    return ok;
  endfunction
endpackage

// ---- tb/otac_bench.sv ----
// bench: issuer and decoder joined by the link, driven from the command side
// assumes the package constants and one 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
module otac_bench;
  import otac_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0; // held low for 8 cycles
  logic dispatch_i = 1'b0;
  logic [1:0] slot_i = 2'h0;
  logic cmd_valid_i = 1'b0;
  otac_type_t cmd_type_i = otac_ty_u8;
  otac_unit_t cmd_unit_i = otac_un_byte;
  logic [15:0] cmd_addr_i = 16'h0000;
  logic [31:0] cmd_data_i = 32'h00000000;
  logic cmd_imm_i = 1'b0;
  logic cmd_eot_i = 1'b0;
  logic cmd_ready_o, result_valid_o, thread_done_o, thread_active_o;
  otac_err_t result_err_o;
  logic [127:0] result_data_o;
  logic [7:0] result_mask_o;
  logic [1:0] thread_slot_id_o;
  int errors = 0;
  int check_count = 0;
  int cycles = 0; // timeout count
  logic sent; // request seen on the link
  logic done; // end seen on the link
  otac_if link();
  otac_device otac_device_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .link(link),
    .thread_slot_id_o(thread_slot_id_o), .thread_active_o(thread_active_o));
  otac_issuer otac_issuer_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .link(link), .dispatch_i(dispatch_i),
    .slot_i(slot_i), .cmd_valid_i(cmd_valid_i), .cmd_type_i(cmd_type_i), .cmd_unit_i(cmd_unit_i),
    .cmd_addr_i(cmd_addr_i), .cmd_data_i(cmd_data_i), .cmd_imm_i(cmd_imm_i), .cmd_eot_i(cmd_eot_i),
    .cmd_ready_o(cmd_ready_o), .result_valid_o(result_valid_o), .result_err_o(result_err_o),
    .result_data_o(result_data_o), .result_mask_o(result_mask_o), .thread_done_o(thread_done_o));
  otac_checker otac_checker_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_valid(link.req_valid),
    .req_type(link.req_type), .req_unit(link.req_unit), .req_addr(link.req_addr), .req_data(link.req_data),
    .req_imm(link.req_imm), .req_eot(link.req_eot), .rsp_valid(link.rsp_valid), .rsp_err(link.rsp_err),
    .rsp_data(link.rsp_data), .rsp_mask(link.rsp_mask), .rsp_done(link.rsp_done));
  // ***************************************************
  // shared tasks
  // ***************************************************
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chk_rsp(input otac_err_t e, input logic [127:0] d, input logic [7:0] m);
    chk({125'h0, result_err_o}, {125'h0, e});
    chk(result_data_o, d);
    chk({120'h0, result_mask_o}, {120'h0, m});
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // one command; waits for ready, then for the result, watching the link
  task automatic access(input otac_type_t t, input otac_unit_t u, input logic [15:0] a,
      input logic [31:0] d, input logic imm, input logic end_of_thread_flag);
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (cmd_ready_o !== 1'b1 && n < 20);
    @(posedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_type_i <= t;
    cmd_unit_i <= u;
    cmd_addr_i <= a;
    cmd_data_i <= d;
    cmd_imm_i <= imm;
    cmd_eot_i <= end_of_thread_flag;
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    sent = 1'b0;
    done = 1'b0;
    n = 0;
    do begin
      @(negedge clk_i);
      sent = sent | (link.req_valid === 1'b1);
      done = done | (link.rsp_done === 1'b1);
      n++;
    end while (result_valid_o !== 1'b1 && n < 20);
    chk({127'h0, result_valid_o}, 128'h1);
  endtask
  // ***************************************************
  // scenarios
  // ***************************************************
  task automatic t_dispatch(input logic [1:0] s, input logic [1:0] exp);
    @(posedge clk_i);
    dispatch_i <= 1'b1;
    slot_i <= s;
    @(posedge clk_i);
    dispatch_i <= 1'b0;
    repeat (3) @(negedge clk_i);
    chk({126'h0, thread_slot_id_o}, {126'h0, exp});
    chk({127'h0, thread_active_o}, 128'h1);
    $display("dispatch slot %0d done", s);
  endtask
  task automatic t_scalar();
    otac_type_t ty[5] = '{otac_ty_u8, otac_ty_u16, otac_ty_s16, otac_ty_s8, otac_ty_u32};
    otac_unit_t un[5] = '{otac_un_byte, otac_un_word, otac_un_word, otac_un_byte, otac_un_dword};
    logic [15:0] ad[5] = '{16'h0003, 16'h0002, 16'h0002, 16'h0000, 16'h0004};
    logic [31:0] ex[5] = '{32'h000000a1, 32'h0000a1b2, 32'hffffa1b2, 32'hffffffd4, 32'ha1b2c3d4};
    for (int i = 0; i < 5; i++) begin
      access(ty[i], un[i], ad[i], 32'ha1b2c3d4, 1'b0, 1'b0);
      chk_rsp(otac_err_none, {96'h0, ex[i]}, 8'h01);
    end
    $display("scalar lanes done");
  endtask
  task automatic t_align();
    for (int u = 2; u <= 6; u++) begin
      access(otac_ty_u32, otac_unit_t'(u), 16'(1 << (u - 2)), 32'h5a5a1234, 1'b0, 1'b0);
      chk_rsp(otac_err_align, 128'h0, 8'h00);
      chk({127'h0, sent}, 128'h0);
      access(otac_ty_u32, otac_unit_t'(u), 16'(1 << (u - 1)), 32'h5a5a1234, 1'b0, 1'b0);
      chk_rsp(otac_err_none, {96'h0, 32'h5a5a1234}, 8'h01);
    end
    access(otac_ty_u8, otac_un_halfbyte, 16'h0000, 32'h0000000f, 1'b0, 1'b0);
    chk_rsp(otac_err_halfbyte, 128'h0, 8'h00);
    chk({127'h0, sent}, 128'h1);
    $display("alignment done");
  endtask
  task automatic t_vectors();
    logic [31:0] d;
    logic [3:0] n;
    logic [127:0] ex;
    d = 32'h8f071a2c;
    for (int i = 0; i < 8; i++) begin
      n = d[4*i +: 4];
      ex[16*i +: 16] = {{12{n[3]}}, n};
    end
    access(otac_ty_nib_vec, otac_un_dword, 16'h0000, d, 1'b1, 1'b0);
    chk_rsp(otac_err_none, ex, 8'hff);
    access(otac_ty_nib_vec, otac_un_dword, 16'h0000, d, 1'b0, 1'b0);
    chk_rsp(otac_err_type, 128'h0, 8'h00);
    // lanes as singles: +0, +2.0, -1.1875, -0
    d = 32'h80b34000;
    ex = 128'h80000000_bf980000_40000000_00000000;
    access(otac_ty_mf_vec, otac_un_dword, 16'h0000, d, 1'b1, 1'b0);
    chk_rsp(otac_err_none, ex, 8'h0f);
    $display("vectors done");
  endtask
  task automatic t_eot();
    access(otac_ty_u32, otac_un_dword, 16'h0008, 32'h13572468, 1'b0, 1'b1);
    chk_rsp(otac_err_none, {96'h0, 32'h13572468}, 8'h01);
    chk({127'h0, done}, 128'h1);
    chk({127'h0, thread_done_o}, 128'h1);
    @(negedge clk_i);
    chk({127'h0, cmd_ready_o}, 128'h0);
    chk({127'h0, thread_active_o}, 128'h0);
    t_dispatch(2'h3, 2'h3);
    $display("thread end done");
  endtask
  // ***************************************************
  // clock, timeout and main sequence
  // ***************************************************
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // hang guard, far above the roughly 110 cycles needed
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      complete_run();
    end
  end
  initial begin
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_dispatch(2'h2, 2'h2);
    t_dispatch(2'h1, 2'h2);
    t_scalar();
    t_align();
    t_vectors();
    t_eot();
    complete_run();
  end
endmodule
`default_nettype wire

// ---- tb/otac_checker.sv ----
// checker: link timing, refusals and operand layout seen on the wires
// assumes one clock and an active-low asynchronous reset for both ends
`timescale 1ns/1ps
`default_nettype none
module otac_checker
  import otac_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic req_valid,
  input wire otac_type_t req_type,
  input wire otac_unit_t req_unit,
  input wire logic [OTAC_ADDR_W-1:0] req_addr,
  input wire logic [OTAC_DATA_W-1:0] req_data,
  input wire logic req_imm,
  input wire logic req_eot,
  input wire logic rsp_valid,
  input wire otac_err_t rsp_err,
  input wire logic [OTAC_RES_W-1:0] rsp_data,
  input wire logic [OTAC_MASK_W-1:0] rsp_mask,
  input wire logic rsp_done
);
  // ***************************************************
  // helper state
  // ***************************************************
  logic [OTAC_DATA_W-1:0] last_data; // operand of the request in flight
  logic [OTAC_ADDR_W-1:0] last_addr;
  // capture on every request; answer comes one cycle later
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      last_data <= 32'h00000000;
      last_addr <= 16'h0000;
    end else if (req_valid) begin
      last_data <= req_data;
      last_addr <= req_addr;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // ***************************************************
  // sequences
  // ***************************************************
  sequence good_rsp_s;
    rsp_valid && rsp_err == otac_err_none;
  endsequence
  sequence vec_req_s(otac_type_t t);
    req_valid && req_type == t && req_imm && req_unit == otac_un_dword;
  endsequence
  // ***************************************************
  // assertions
  // ***************************************************
  a_rsp_one_after:
    assert property (req_valid |=> rsp_valid) else $error("request not answered next cycle");
  a_rsp_has_cause:
    assert property (rsp_valid |-> $past(req_valid)) else $error("answer without request");
  a_word_odd_refused:
    assert property (req_valid && req_unit == otac_un_word && req_addr[0]
      |=> rsp_err inside {otac_err_align, otac_err_dead}) else $error("odd word address taken");
  a_dword_skew_refused:
    assert property (req_valid && req_unit == otac_un_dword && req_addr[1:0] != 2'h0
      |=> rsp_err inside {otac_err_align, otac_err_dead}) else $error("unaligned dword taken");
  a_group_skew_refused:
    assert property (req_valid && ((req_unit == otac_un_sixty_four_bit_unit && req_addr[2:0] != 3'h0)
      || (req_unit == otac_un_dqword && req_addr[3:0] != 4'h0)
      || (req_unit == otac_un_two_fifty_six_bit_unit && req_addr[4:0] != 5'h00))
      |=> rsp_err inside {otac_err_align, otac_err_dead}) else $error("unaligned group taken");
  a_halfbyte_refused:
    assert property (req_valid && req_unit == otac_un_halfbyte
      |=> rsp_err inside {otac_err_halfbyte, otac_err_dead}) else $error("halfbyte access taken");
  a_refused_empty:
    assert property (rsp_valid && rsp_err != otac_err_none |-> rsp_data == 128'h0 && rsp_mask == 8'h00)
      else $error("refused answer carries data");
  a_nib_sign_ext:
    assert property (vec_req_s(otac_ty_nib_vec) ##1 good_rsp_s |-> rsp_mask == 8'hff
      && rsp_data[15:0] == {{12{last_data[3]}}, last_data[3:0]}
      && rsp_data[127:112] == {{12{last_data[31]}}, last_data[31:28]}) else $error("nibble lanes wrong");
  a_mf_lane_order:
    assert property (vec_req_s(otac_ty_mf_vec) ##1 good_rsp_s |-> rsp_mask == 8'h0f
      && rsp_data[31] == last_data[7] && rsp_data[127] == last_data[31]) else $error("minifloat lanes wrong");
  a_sword_sign_ext:
    assert property (req_valid && req_type == otac_ty_s16 && req_unit == otac_un_word ##1 good_rsp_s
      |-> rsp_data[31:0] == (last_addr[1] ? {{16{last_data[31]}}, last_data[31:16]}
      : {{16{last_data[15]}}, last_data[15:0]})) else $error("signed word not extended");
  a_ubyte_zero_ext:
    assert property (req_valid && req_type == otac_ty_u8 && req_unit == otac_un_byte ##1 good_rsp_s
      |-> rsp_data[31:0] == {24'h000000, last_data[8*last_addr[1:0] +: 8]}) else $error("byte lane wrong");
  a_big_unit_raw:
    assert property (req_valid && req_unit inside {otac_un_sixty_four_bit_unit, otac_un_dqword,
      otac_un_two_fifty_six_bit_unit} ##1 good_rsp_s |-> rsp_mask == 8'h01 && rsp_data[31:0] == last_data)
      else $error("group unit treated as number");
  a_link_req_aligned:
    assert property (req_valid && req_unit != otac_un_halfbyte |-> otac_aligned(req_unit, req_addr))
      else $error("misaligned request reached the link");
  a_eot_ends:
    assert property (req_valid && req_eot |=> rsp_valid && rsp_done) else $error("end flag not honoured");
endmodule
`default_nettype wire
